// ### core/msb_pkg.sv
// Purpose: Shared constants for the special function register bank and its processor-side driver
// Assumes: 8-bit register bus, one clock domain
// Notes:   Offsets are bus addresses of the bank; host offsets are its own command port
package msb_pkg;
   // Bank register offsets
   localparam logic [7:0] EEPROM_DATA_OFS = 8'h9E;
   localparam logic [7:0] EEPROM_CMD_OFS  = 8'h9F;
   localparam logic [7:0] FLASH_CTRL_OFS  = 8'hB2;
   localparam logic [7:0] ERASE_CMD_OFS   = 8'hB6;
   localparam logic [7:0] ERASE_PAGE_OFS  = 8'hB7;
   localparam logic [7:0] MP_FLAGS_OFS    = 8'hE8;
   localparam logic [7:0] IRQ_LEVELS_OFS  = 8'hF8;

   // Erase command patterns
   localparam logic [7:0] ERASE_PAGE_CMD = 8'h55;
   localparam logic [7:0] ERASE_MASS_CMD = 8'hAA;

   // Flash control fields
   localparam int FC_PWE_BIT     = 0;
   localparam int FC_MEEN_BIT    = 1;
   localparam int FC_SECURE_BIT  = 6;
   localparam int FC_PREBOOT_BIT = 7;

   // Multi-purpose flag fields
   localparam int MPF_XFER_BIT = 0;
   localparam int MPF_TICK_BIT = 1;
   localparam int MPF_COUNT    = 2;

   // Reset values
   localparam logic [7:0]  BYTE_RST       = 8'h00;
   localparam logic [7:0]  ERASE_PAGE_RST = 8'h00;
   localparam logic [15:0] WORD_RST       = 16'h0000;

   // Widths
   localparam int PAGE_NUM_W = 7;
   localparam int IRQ_IN_W   = 7;

   // Host command port offsets
   localparam logic [3:0] H_ADDR_OFS   = 4'h0;
   localparam logic [3:0] H_DATA_OFS   = 4'h1;
   localparam logic [3:0] H_CTRL_OFS   = 4'h2;
   localparam logic [3:0] H_INTEN_OFS  = 4'h3;
   localparam logic [3:0] H_DPLO_OFS   = 4'h4;
   localparam logic [3:0] H_DPHI_OFS   = 4'h5;
   localparam logic [3:0] H_RDBACK_OFS = 4'h6;
   localparam logic [3:0] H_STATUS_OFS = 4'h7;
   localparam logic [3:0] H_MASK_OFS   = 4'h8;

   // Host control and status fields
   localparam int HC_WRITE_BIT = 0;
   localparam int HC_READ_BIT  = 1;
   localparam int HC_MOVX_BIT  = 2;
   localparam int HS_RDONE_BIT = 0;
   localparam int HS_FLAG_BIT  = 1;
   localparam int HS_COUNT     = 2;
endpackage : msb_pkg

// ### core/msb_sfr_if.sv
// Purpose: Special function bus between processor side and register bank
// Assumes: Single clock, all signals driven from flip-flops
// Notes:   Read data stands in the cycle after the read strobe
`timescale 1ns/10ps
interface msb_sfr_if;
   logic [7:0]  sfrAddr;
   logic [7:0]  sfrWdata;
   logic        sfrWr;
   logic        sfrRd;
   logic [7:0]  sfrRdata;
   logic        cpuIntEnable;
   logic        movxWr;
   logic [15:0] movxAddr;
   logic [7:0]  movxData;
   logic        flagIrq;

   modport cpu (
      output sfrAddr, sfrWdata, sfrWr, sfrRd, cpuIntEnable, movxWr, movxAddr, movxData,
      input  sfrRdata, flagIrq
   );
   modport bank (
      input  sfrAddr, sfrWdata, sfrWr, sfrRd, cpuIntEnable, movxWr, movxAddr, movxData,
      output sfrRdata, flagIrq
   );
endinterface : msb_sfr_if

// ### core/msb_sticky_flag.sv
// Purpose: One hardware-set, software-cleared flag
// Assumes: Set and clear are single-cycle terms on sys_clk
// Notes:   Set beats clear so no event is lost
`timescale 1ns/10ps
module msb_sticky_flag (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic setPulse,
   input  wire logic clearReq,
   output logic      flag
);
   typedef struct packed {
      logic flag;
   } msb_flag_st_t;

   msb_flag_st_t st;
   msb_flag_st_t next_st;

   always_comb begin
      next_st = st;
      if (clearReq) begin
         next_st.flag = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (setPulse) begin
         next_st.flag = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign flag = st.flag;
endmodule : msb_sticky_flag

// ### core/msb_sfr_bank.sv
// Purpose: Device-specific special function register bank
// Assumes: Processor strobes are single-cycle; event inputs come from logic on sys_clk
// Notes:   Interrupt levels and debug enable are pins and are synchronised first
//
// Design decision made here: strobed register access.
`timescale 1ns/10ps
module msb_sfr_bank #(
   parameter logic [7:0] EEPROM_TX_CODE = 8'h01
) (
   input  wire logic                         sys_clk,
   input  wire logic                         rst_n,
   input  wire logic                         ce,
   msb_sfr_if.bank                           bus,
   input  wire logic                         debugPortEn,
   input  wire logic                         prebootActive,
   input  wire logic                         transferBusyEvent,
   input  wire logic                         slowPeriodicEvent,
   input  wire logic [msb_pkg::IRQ_IN_W-1:0] externalIrqInputs,
   output logic                              pageEraseStart,
   output logic [msb_pkg::PAGE_NUM_W-1:0]    erasePageNumber,
   output logic                              massEraseStart,
   output logic                              eepromTxStart,
   output logic [7:0]                        eepromDataByte,
   output logic [7:0]                        eepromCommand,
   output logic                              flashProgWrite,
   output logic                              xramWrite,
   output logic [15:0]                       memAddr,
   output logic [7:0]                        memData,
   output logic                              secureLock,
   output logic [msb_pkg::MPF_COUNT-1:0]     multiPurposeFlags
);
   localparam int SYNC_W = msb_pkg::IRQ_IN_W + 1;

   typedef struct packed {
      logic [7:0]        rdata;
      logic [7:0]        eeprom_data_byte;
      logic [7:0]        eeCmd;
      logic [7:0]        pageNum;
      logic              pageArmed;
      logic              pwe;
      logic              meen;
      logic              secure;
      logic              pageStart;
      logic              massStart;
      logic              txStart;
      logic              progWr;
      logic              xramWr;
      logic [15:0]       addr;
      logic [7:0]        data;
      logic [SYNC_W-1:0] sync1;
      logic [SYNC_W-1:0] sync2;
      logic              flagIrq;
   } msb_bank_st_t;

   msb_bank_st_t st;
   msb_bank_st_t next_st;

   logic [msb_pkg::MPF_COUNT-1:0] flagSet;
   logic [msb_pkg::MPF_COUNT-1:0] flagClr;
   logic                          wrFlags;
   logic                          irqEnSync;
   logic [msb_pkg::IRQ_IN_W-1:0]  irqLevels;

   assign wrFlags   = bus.sfrWr && (bus.sfrAddr == msb_pkg::MP_FLAGS_OFS);
   assign irqEnSync = st.sync2[msb_pkg::IRQ_IN_W];
   assign irqLevels = st.sync2[msb_pkg::IRQ_IN_W-1:0];

   always_comb begin
      flagSet = '0;
      flagSet[msb_pkg::MPF_XFER_BIT] = transferBusyEvent;
      flagSet[msb_pkg::MPF_TICK_BIT] = slowPeriodicEvent;
   end

   // Whole-byte write: a zero clears, a one leaves the bit alone
   genvar gi;
   generate
      for (gi = 0; gi < msb_pkg::MPF_COUNT; gi++) begin : g_flag
         assign flagClr[gi] = wrFlags && !bus.sfrWdata[gi];
         msb_sticky_flag u_flag (
            .sys_clk  (sys_clk),
            .rst_n    (rst_n),
            .ce       (ce),
            .setPulse (flagSet[gi]),
            .clearReq (flagClr[gi]),
            .flag     (multiPurposeFlags[gi])
         );
      end
   endgenerate

   always_comb begin
      next_st = st;
      next_st.pageStart = 1'b0;
      next_st.massStart = 1'b0;
      next_st.txStart   = 1'b0;
      next_st.progWr    = 1'b0;
      next_st.xramWr    = 1'b0;
      // Pins pass two flops before anyone looks at them
      next_st.sync1 = {debugPortEn, externalIrqInputs};
      next_st.sync2 = st.sync1;
      next_st.flagIrq = |multiPurposeFlags;

      // External data move: flash when enabled, else external RAM
      if (bus.movxWr) begin
         next_st.addr = bus.movxAddr;
         next_st.data = bus.movxData;
         if (st.pwe) begin
            next_st.progWr = 1'b1;
            next_st.pwe    = 1'b0;
         end else begin
            next_st.xramWr = 1'b1;
         end
      end

      if (bus.sfrWr) begin
         case (bus.sfrAddr)
            msb_pkg::EEPROM_DATA_OFS: begin
               next_st.eeprom_data_byte = bus.sfrWdata;
            end
            msb_pkg::EEPROM_CMD_OFS: begin
               next_st.eeCmd = bus.sfrWdata;
               // Data byte must already be loaded; only the command write launches
               if (bus.sfrWdata == EEPROM_TX_CODE) begin
                  next_st.txStart = 1'b1;
               end
            end
            msb_pkg::FLASH_CTRL_OFS: begin
               // Interrupts must be off so an ISR cannot hijack a flash write
               if (!bus.cpuIntEnable) begin
                  next_st.pwe = bus.sfrWdata[msb_pkg::FC_PWE_BIT];
               end
               next_st.meen = bus.sfrWdata[msb_pkg::FC_MEEN_BIT];
               if (bus.sfrWdata[msb_pkg::FC_SECURE_BIT]) begin
                  next_st.secure = 1'b1;
               end
            end
            msb_pkg::ERASE_PAGE_OFS: begin
               next_st.pageNum   = bus.sfrWdata;
               next_st.pageArmed = 1'b1;
            end
            msb_pkg::ERASE_CMD_OFS: begin
               if (bus.sfrWdata == msb_pkg::ERASE_PAGE_CMD && st.pageArmed) begin
                  next_st.pageStart = 1'b1;
                  next_st.pageArmed = 1'b0;
               end else if (bus.sfrWdata == msb_pkg::ERASE_MASS_CMD && st.meen && irqEnSync) begin
                  next_st.massStart = 1'b1;
                  next_st.meen      = 1'b0;
               end
               // Any other pattern starts nothing
            end
            default: begin
            end
         endcase
      end

      // Read data valid in the cycle after the strobe only
      next_st.rdata = msb_pkg::BYTE_RST;
      if (bus.sfrRd) begin
         case (bus.sfrAddr)
            msb_pkg::EEPROM_DATA_OFS: begin
               next_st.rdata = st.eeprom_data_byte;
            end
            msb_pkg::EEPROM_CMD_OFS: begin
               next_st.rdata = st.eeCmd;
            end
            msb_pkg::FLASH_CTRL_OFS: begin
               next_st.rdata[msb_pkg::FC_PWE_BIT]     = st.pwe;
               next_st.rdata[msb_pkg::FC_MEEN_BIT]    = st.meen;
               next_st.rdata[msb_pkg::FC_SECURE_BIT]  = st.secure;
               next_st.rdata[msb_pkg::FC_PREBOOT_BIT] = prebootActive;
            end
            msb_pkg::ERASE_PAGE_OFS: begin
               next_st.rdata = st.pageNum;
            end
            msb_pkg::MP_FLAGS_OFS: begin
               next_st.rdata[msb_pkg::MPF_COUNT-1:0] = multiPurposeFlags;
            end
            msb_pkg::IRQ_LEVELS_OFS: begin
               // No latch: live synchronised levels only
               next_st.rdata[msb_pkg::IRQ_IN_W-1:0] = irqLevels;
            end
            default: begin
               // Unmapped and write-only addresses read zero
               next_st.rdata = msb_pkg::BYTE_RST;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st         <= '0;
         st.pageNum <= msb_pkg::ERASE_PAGE_RST;
         st.eeprom_data_byte  <= msb_pkg::BYTE_RST;
         st.eeCmd   <= msb_pkg::BYTE_RST;
         st.addr    <= msb_pkg::WORD_RST;
         st.data    <= msb_pkg::BYTE_RST;
         st.secure  <= 1'b0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign bus.sfrRdata    = st.rdata;
   assign bus.flagIrq     = st.flagIrq;
   assign pageEraseStart  = st.pageStart;
   assign erasePageNumber = st.pageNum[msb_pkg::PAGE_NUM_W-1:0];
   assign massEraseStart  = st.massStart;
   assign eepromTxStart   = st.txStart;
   assign eepromDataByte  = st.eeprom_data_byte;
   assign eepromCommand   = st.eeCmd;
   assign flashProgWrite  = st.progWr;
   assign xramWrite       = st.xramWr;
   assign memAddr         = st.addr;
   assign memData         = st.data;
   // Flash and engine RAM readers outside gate on this
   assign secureLock      = st.secure;
endmodule : msb_sfr_bank

// ### core/msb_sfr_host.sv
// Purpose: Processor-side driver of the special function bus, steered by a command port
// Assumes: Software issues one command at a time
// Notes:   Status is write-one-to-clear, irq is registered
`timescale 1ns/10ps
module msb_sfr_host (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   msb_sfr_if.cpu          bus,
   input  wire logic [3:0] userAddr,
   input  wire logic [7:0] userWdata,
   input  wire logic       userWr,
   input  wire logic       userRd,
   output logic      [7:0] userRdata,
   output logic            irq
);
   typedef struct packed {
      logic [7:0]                     addr;
      logic [7:0]                     data;
      logic [15:0]                    dptr;
      logic                           intEn;
      logic [7:0]                     rdback;
      logic [msb_pkg::HS_COUNT-1:0]   status;
      logic [msb_pkg::HS_COUNT-1:0]   mask;
      logic                           busWr;
      logic                           busRd;
      logic                           rdWait;
      logic                           movxWr;
      logic                           flagD;
      logic [7:0]                     rdata;
      logic                           irq;
   } msb_host_st_t;

   msb_host_st_t st;
   msb_host_st_t next_st;

   logic [msb_pkg::HS_COUNT-1:0] evt;

   always_comb begin
      next_st = st;
      next_st.busWr  = 1'b0;
      next_st.busRd  = 1'b0;
      next_st.movxWr = 1'b0;
      next_st.rdWait = st.busRd;
      next_st.flagD  = bus.flagIrq;
      evt = '0;
      if (st.rdWait) begin
         next_st.rdback = bus.sfrRdata;
         evt[msb_pkg::HS_RDONE_BIT] = 1'b1;
      end
      evt[msb_pkg::HS_FLAG_BIT] = bus.flagIrq && !st.flagD;
      if (userWr) begin
         case (userAddr)
            msb_pkg::H_ADDR_OFS: next_st.addr = userWdata;
            msb_pkg::H_DATA_OFS: next_st.data = userWdata;
            msb_pkg::H_CTRL_OFS: begin
               // Write wins if software sets both strobes at once
               next_st.busWr  = userWdata[msb_pkg::HC_WRITE_BIT];
               next_st.busRd  = userWdata[msb_pkg::HC_READ_BIT] && !userWdata[msb_pkg::HC_WRITE_BIT];
               next_st.movxWr = userWdata[msb_pkg::HC_MOVX_BIT];
            end
            msb_pkg::H_INTEN_OFS: next_st.intEn = userWdata[0];
            msb_pkg::H_DPLO_OFS: next_st.dptr[7:0] = userWdata;
            msb_pkg::H_DPHI_OFS: next_st.dptr[15:8] = userWdata;
            msb_pkg::H_STATUS_OFS: next_st.status = st.status & ~userWdata[msb_pkg::HS_COUNT-1:0];
            msb_pkg::H_MASK_OFS: next_st.mask = userWdata[msb_pkg::HS_COUNT-1:0];
            default: begin
            end
         endcase
      end
      // New events beat a clear in the same cycle
      next_st.status = next_st.status | evt;
      next_st.irq = |(st.status & st.mask);
      next_st.rdata = msb_pkg::BYTE_RST;
      if (userRd) begin
         case (userAddr)
            msb_pkg::H_ADDR_OFS: next_st.rdata = st.addr;
            msb_pkg::H_DATA_OFS: next_st.rdata = st.data;
            msb_pkg::H_INTEN_OFS: next_st.rdata = {7'h00, st.intEn};
            msb_pkg::H_DPLO_OFS: next_st.rdata = st.dptr[7:0];
            msb_pkg::H_DPHI_OFS: next_st.rdata = st.dptr[15:8];
            msb_pkg::H_RDBACK_OFS: next_st.rdata = st.rdback;
            msb_pkg::H_STATUS_OFS: next_st.rdata = {6'h00, st.status};
            msb_pkg::H_MASK_OFS: next_st.rdata = {6'h00, st.mask};
            default: next_st.rdata = msb_pkg::BYTE_RST;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign bus.sfrAddr      = st.addr;
   assign bus.sfrWdata     = st.data;
   assign bus.sfrWr        = st.busWr;
   assign bus.sfrRd        = st.busRd;
   // Flag register writes from software must carry ones in bits to
   assign bus.cpuIntEnable = st.intEn;
   assign bus.movxWr       = st.movxWr;
   assign bus.movxAddr     = st.dptr;
   assign bus.movxData     = st.data;
   assign userRdata        = st.rdata;
   assign irq              = st.irq;
endmodule : msb_sfr_host

// ### testbench/msb_sfr_properties.sv
// Purpose: Bus-level checks of the register bank, watching the interface only
// Assumes: One clock; host issues one command at a time
// Notes:   Helpers mirror what software wrote, so reads can be judged
`timescale 1ns/10ps
module msb_sfr_properties (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [7:0]  sfrAddr,
   input wire logic [7:0]  sfrWdata,
   input wire logic        sfrWr,
   input wire logic        sfrRd,
   input wire logic [7:0]  sfrRdata,
   input wire logic        cpuIntEnable,
   input wire logic        movxWr,
   input wire logic [15:0] movxAddr,
   input wire logic [7:0]  movxData,
   input wire logic        flagIrq
);
   logic [7:0] pageHeld;
   logic [7:0] eeHeld;
   logic       secSeen;
   logic       pweHeld;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // Mirrors of written values; program enable cleared by any move
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pageHeld <= 8'h00;
         eeHeld   <= 8'h00;
         secSeen  <= 1'b0;
         pweHeld  <= 1'b0;
      end else begin
         if (sfrWr && sfrAddr == msb_pkg::ERASE_PAGE_OFS) pageHeld <= sfrWdata;
         if (sfrWr && sfrAddr == msb_pkg::EEPROM_DATA_OFS) eeHeld <= sfrWdata;
         if (sfrWr && sfrAddr == msb_pkg::FLASH_CTRL_OFS && sfrWdata[6]) secSeen <= 1'b1;
         if (sfrWr && sfrAddr == msb_pkg::FLASH_CTRL_OFS && !cpuIntEnable) pweHeld <= sfrWdata[0];
         else if (movxWr) pweHeld <= 1'b0;
      end
   end

   sequence readAt(logic [7:0] a);
      sfrRd && sfrAddr == a;
   endsequence
   // A flag write just before leaves flagIrq one cycle stale
   sequence keepWrite;
      sfrWr && sfrAddr == msb_pkg::MP_FLAGS_OFS && sfrWdata[1:0] == 2'b11 && flagIrq
         && !$past(sfrWr && sfrAddr == msb_pkg::MP_FLAGS_OFS);
   endsequence

   AST_ERASE_READ_ZERO: assert property (readAt(msb_pkg::ERASE_CMD_OFS) |=> sfrRdata == 8'h00)
      else $error("erase command reads nonzero");
   AST_PAGE_READBACK: assert property (readAt(msb_pkg::ERASE_PAGE_OFS) |=> sfrRdata == $past(pageHeld))
      else $error("page number readback wrong");
   AST_EEPROM_DATA_BYTE_READBACK: assert property (readAt(msb_pkg::EEPROM_DATA_OFS) |=> sfrRdata == $past(eeHeld))
      else $error("eeprom data readback wrong");
   AST_PWE_READ: assert property (readAt(msb_pkg::FLASH_CTRL_OFS) |=> sfrRdata[0] == $past(pweHeld))
      else $error("program enable bit wrong");
   AST_SECURE_READ: assert property (readAt(msb_pkg::FLASH_CTRL_OFS) |=> sfrRdata[6] == $past(secSeen))
      else $error("security bit wrong");
   AST_LEVELS_TOP: assert property (readAt(msb_pkg::IRQ_LEVELS_OFS) |=> !sfrRdata[7])
      else $error("level register bit 7 set");
   AST_FLAG_KEEP: assert property (keepWrite |=> ##1 flagIrq)
      else $error("flag lost on write of ones");
   AST_FLAG_IRQ_MATCH: assert property (readAt(msb_pkg::MP_FLAGS_OFS) |=> (|sfrRdata[1:0]) == flagIrq)
      else $error("flag read and flag irq disagree");
endmodule : msb_sfr_properties

// ### testbench/test_mcu_specific_sfr_bank.sv
// Purpose: Self-checking bench of host driver and register bank joined by the bus
// Assumes: Host command port is the only software path
// Notes:   Pulse outputs are counted, so a missed or extra start shows
`timescale 1ns/10ps
module test_mcu_specific_sfr_bank;
   localparam logic [7:0] TX_CODE = 8'h01;
   logic       sys_clk = 1'b0;
   logic       rst_n;
   logic [3:0] userAddr;
   logic [7:0] userWdata, userRdata, rd;
   logic       userWr, userRd, irq;
   logic       debugPortEn, prebootActive, transferBusyEvent, slowPeriodicEvent;
   logic [6:0] externalIrqInputs, erasePageNumber;
   logic       pageEraseStart, massEraseStart, eepromTxStart, flashProgWrite, xramWrite, secureLock;
   logic [7:0] eepromDataByte, eepromCommand, memData;
   logic [15:0] memAddr;
   logic [1:0] multiPurposeFlags;
   logic [7:0] pgCnt = 8'h00, msCnt = 8'h00, txCnt = 8'h00, fwCnt = 8'h00, xwCnt = 8'h00;
   int         mismatches = 0;
   int         totalChecks = 0;

   always #2.5 sys_clk = ~sys_clk;

   msb_sfr_if msb_sfr_if_i ();
   msb_sfr_host msb_sfr_host_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .bus(msb_sfr_if_i),
      .userAddr(userAddr), .userWdata(userWdata), .userWr(userWr), .userRd(userRd),
      .userRdata(userRdata), .irq(irq));
   msb_sfr_bank #(.EEPROM_TX_CODE(TX_CODE)) msb_sfr_bank_i (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1),
      .bus(msb_sfr_if_i), .debugPortEn(debugPortEn), .prebootActive(prebootActive),
      .transferBusyEvent(transferBusyEvent), .slowPeriodicEvent(slowPeriodicEvent),
      .externalIrqInputs(externalIrqInputs), .pageEraseStart(pageEraseStart),
      .erasePageNumber(erasePageNumber), .massEraseStart(massEraseStart), .eepromTxStart(eepromTxStart),
      .eepromDataByte(eepromDataByte), .eepromCommand(eepromCommand), .flashProgWrite(flashProgWrite),
      .xramWrite(xramWrite), .memAddr(memAddr), .memData(memData), .secureLock(secureLock),
      .multiPurposeFlags(multiPurposeFlags));
   msb_sfr_properties msb_sfr_properties_i (.sys_clk(sys_clk), .rst_n(rst_n),
      .sfrAddr(msb_sfr_if_i.sfrAddr), .sfrWdata(msb_sfr_if_i.sfrWdata), .sfrWr(msb_sfr_if_i.sfrWr),
      .sfrRd(msb_sfr_if_i.sfrRd), .sfrRdata(msb_sfr_if_i.sfrRdata), .cpuIntEnable(msb_sfr_if_i.cpuIntEnable),
      .movxWr(msb_sfr_if_i.movxWr), .movxAddr(msb_sfr_if_i.movxAddr), .movxData(msb_sfr_if_i.movxData),
      .flagIrq(msb_sfr_if_i.flagIrq));

   // Start pulses stand one cycle, so count them at every edge
   always @(posedge sys_clk) begin
      if (pageEraseStart === 1'b1) pgCnt <= pgCnt + 8'h01;
      if (massEraseStart === 1'b1) msCnt <= msCnt + 8'h01;
      if (eepromTxStart === 1'b1) txCnt <= txCnt + 8'h01;
      if (flashProgWrite === 1'b1) fwCnt <= fwCnt + 8'h01;
      if (xramWrite === 1'b1) xwCnt <= xwCnt + 8'h01;
   end

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", totalChecks, mismatches);
      if (mismatches == 0 && totalChecks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      totalChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic uwr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      userAddr  <= a;
      userWdata <= d;
      userWr    <= 1'b1;
      @(posedge sys_clk);
      userWr    <= 1'b0;
   endtask : uwr

   task automatic urd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      userAddr <= a;
      userRd   <= 1'b1;
      @(posedge sys_clk);
      userRd   <= 1'b0;
      #1;
      d = userRdata;
   endtask : urd

   // Bank write: address, data, then command; effects settle three edges on
   task automatic sfrW(input logic [7:0] a, input logic [7:0] d);
      uwr(msb_pkg::H_ADDR_OFS, a);
      uwr(msb_pkg::H_DATA_OFS, d);
      uwr(msb_pkg::H_CTRL_OFS, 8'h01);
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : sfrW

   // Bank read through read-back, then clear the read-done status
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      uwr(msb_pkg::H_ADDR_OFS, a);
      uwr(msb_pkg::H_CTRL_OFS, 8'h02);
      repeat (3) @(posedge sys_clk);
      urd(msb_pkg::H_RDBACK_OFS, rd);
      chk(rd, exp);
      uwr(msb_pkg::H_STATUS_OFS, 8'h01);
   endtask : rdChk

   task automatic movx;
      uwr(msb_pkg::H_CTRL_OFS, 8'h04);
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : movx

   task automatic chkIrq(input logic exp);
      repeat (3) @(posedge sys_clk);
      #1;
      chk({7'h00, irq}, {7'h00, exp});
   endtask : chkIrq

   task automatic pulseEvt(input logic slow);
      @(posedge sys_clk);
      slowPeriodicEvent <= slow;
      transferBusyEvent <= !slow;
      @(posedge sys_clk);
      slowPeriodicEvent <= 1'b0;
      transferBusyEvent <= 1'b0;
   endtask : pulseEvt

   // Run takes about five hundred cycles; far beyond that means a hang
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      test_done();
   end

   initial begin
      rst_n = 1'b0;
      userAddr = 4'h0;
      userWdata = 8'h00;
      userWr = 1'b0;
      userRd = 1'b0;
      debugPortEn = 1'b0;
      prebootActive = 1'b0;
      transferBusyEvent = 1'b0;
      slowPeriodicEvent = 1'b0;
      externalIrqInputs = 7'h00;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rdChk(msb_pkg::ERASE_PAGE_OFS, msb_pkg::ERASE_PAGE_RST);
      rdChk(msb_pkg::ERASE_CMD_OFS, 8'h00);
      rdChk(msb_pkg::FLASH_CTRL_OFS, 8'h00);
      rdChk(8'h80, 8'h00);
      sfrW(msb_pkg::ERASE_PAGE_OFS, 8'h05);
      sfrW(msb_pkg::ERASE_CMD_OFS, msb_pkg::ERASE_PAGE_CMD);
      chk(pgCnt, 8'h01);
      chk({1'b0, erasePageNumber}, 8'h05);
      sfrW(msb_pkg::ERASE_CMD_OFS, msb_pkg::ERASE_PAGE_CMD);
      chk(pgCnt, 8'h01);
      sfrW(msb_pkg::ERASE_PAGE_OFS, 8'h7F);
      sfrW(msb_pkg::ERASE_CMD_OFS, 8'h00);
      sfrW(msb_pkg::ERASE_CMD_OFS, 8'h12);
      sfrW(msb_pkg::ERASE_CMD_OFS, msb_pkg::ERASE_MASS_CMD);
      chk(pgCnt + msCnt, 8'h01);
      sfrW(msb_pkg::ERASE_CMD_OFS, msb_pkg::ERASE_PAGE_CMD);
      chk(pgCnt, 8'h02);
      chk({1'b0, erasePageNumber}, 8'h7F);
      rdChk(msb_pkg::ERASE_PAGE_OFS, 8'h7F);
      @(posedge sys_clk) debugPortEn <= 1'b1;
      sfrW(msb_pkg::FLASH_CTRL_OFS, 8'h02);
      sfrW(msb_pkg::ERASE_CMD_OFS, msb_pkg::ERASE_MASS_CMD);
      chk(msCnt, 8'h01);
      sfrW(msb_pkg::ERASE_CMD_OFS, msb_pkg::ERASE_MASS_CMD);
      chk(msCnt, 8'h01);
      @(posedge sys_clk) debugPortEn <= 1'b0;
      sfrW(msb_pkg::FLASH_CTRL_OFS, 8'h02);
      sfrW(msb_pkg::ERASE_CMD_OFS, msb_pkg::ERASE_MASS_CMD);
      chk(msCnt, 8'h01);
      sfrW(msb_pkg::EEPROM_DATA_OFS, 8'hA5);
      sfrW(msb_pkg::EEPROM_CMD_OFS, TX_CODE);
      chk(txCnt, 8'h01);
      chk(eepromDataByte, 8'hA5);
      chk(eepromCommand, TX_CODE);
      sfrW(msb_pkg::EEPROM_CMD_OFS, ~TX_CODE);
      chk(txCnt, 8'h01);
      rdChk(msb_pkg::EEPROM_DATA_OFS, 8'hA5);
      sfrW(msb_pkg::FLASH_CTRL_OFS, 8'h01);
      rdChk(msb_pkg::FLASH_CTRL_OFS, 8'h01);
      uwr(msb_pkg::H_DPLO_OFS, 8'h34);
      uwr(msb_pkg::H_DPHI_OFS, 8'h12);
      uwr(msb_pkg::H_DATA_OFS, 8'h5A);
      movx();
      chk(fwCnt, 8'h01);
      chk(memAddr[15:8], 8'h12);
      chk(memAddr[7:0], 8'h34);
      chk(memData, 8'h5A);
      rdChk(msb_pkg::FLASH_CTRL_OFS, 8'h00);
      movx();
      chk(xwCnt, 8'h01);
      uwr(msb_pkg::H_INTEN_OFS, 8'h01);
      sfrW(msb_pkg::FLASH_CTRL_OFS, 8'h01);
      rdChk(msb_pkg::FLASH_CTRL_OFS, 8'h00);
      uwr(msb_pkg::H_INTEN_OFS, 8'h00);
      @(posedge sys_clk) prebootActive <= 1'b1;
      rdChk(msb_pkg::FLASH_CTRL_OFS, 8'h80);
      @(posedge sys_clk) prebootActive <= 1'b0;
      uwr(msb_pkg::H_MASK_OFS, 8'h02);
      pulseEvt(1'b0);
      rdChk(msb_pkg::MP_FLAGS_OFS, 8'h01);
      chkIrq(1'b1);
      urd(msb_pkg::H_STATUS_OFS, rd);
      chk(rd, 8'h02);
      pulseEvt(1'b1);
      rdChk(msb_pkg::MP_FLAGS_OFS, 8'h03);
      chk({6'h00, multiPurposeFlags}, 8'h03);
      sfrW(msb_pkg::MP_FLAGS_OFS, 8'hFF);
      rdChk(msb_pkg::MP_FLAGS_OFS, 8'h03);
      sfrW(msb_pkg::MP_FLAGS_OFS, 8'hFE);
      rdChk(msb_pkg::MP_FLAGS_OFS, 8'h02);
      uwr(msb_pkg::H_MASK_OFS, 8'h00);
      chkIrq(1'b0);
      uwr(msb_pkg::H_MASK_OFS, 8'h02);
      chkIrq(1'b1);
      sfrW(msb_pkg::MP_FLAGS_OFS, 8'hFD);
      rdChk(msb_pkg::MP_FLAGS_OFS, 8'h00);
      uwr(msb_pkg::H_STATUS_OFS, 8'h02);
      chkIrq(1'b0);
      @(posedge sys_clk) externalIrqInputs <= 7'h55;
      rdChk(msb_pkg::IRQ_LEVELS_OFS, 8'h55);
      @(posedge sys_clk) externalIrqInputs <= 7'h2A;
      rdChk(msb_pkg::IRQ_LEVELS_OFS, 8'h2A);
      sfrW(msb_pkg::FLASH_CTRL_OFS, 8'h40);
      chk({7'h00, secureLock}, 8'h01);
      sfrW(msb_pkg::FLASH_CTRL_OFS, 8'h00);
      rdChk(msb_pkg::FLASH_CTRL_OFS, 8'h40);
      @(posedge sys_clk) rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk({7'h00, secureLock}, 8'h00);
      rdChk(msb_pkg::FLASH_CTRL_OFS, 8'h00);
      test_done();
   end
endmodule : test_mcu_specific_sfr_bank
